/* rst_seq_consts.vh */
// constants for the reset sequencer and configuration decode
// assumes a 100 MHz system clock and a 14-bit configuration word
`ifndef RST_SEQ_CONSTS_VH
`define RST_SEQ_CONSTS_VH
// configuration word field positions
`define CFG_OSC_LSB 0
`define CFG_OSC_MSB 2
`define CFG_WDT_BIT 3
`define CFG_DELAY_DIS_BIT 4
`define CFG_EXTRST_BIT 5
`define CFG_CODEPROT_BIT 6
`define CFG_DATAPROT_BIT 7
`define CFG_BOR_LSB 8
`define CFG_BOR_MSB 9
// brown-out mode codes
`define BOR_MODE_ALWAYS 2'b11
`define BOR_MODE_RUN 2'b10
`define BOR_MODE_SOFT 2'b01
// oscillator select codes
`define OSC_RC_CLKOUT 3'b111
`define OSC_RC_IO 3'b110
`define OSC_INT_CLKOUT 3'b101
`define OSC_INT_IO 3'b100
`define OSC_EXT_CLK 3'b011
`define OSC_FAST_XTAL 3'b010
`define OSC_XTAL_RES 3'b001
// one-hot oscillator mode outputs
`define OSC_ONEHOT_W 8
// timing: clock period in ns, times in their own units
`define CLK_PERIOD_NS 10
`define POR_REARM_US 100
`define POR_REARM_CYC ((`POR_REARM_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PUP_DELAY_MS 64
`define PUP_DELAY_CYC ((`PUP_DELAY_MS * 1000000) / `CLK_PERIOD_NS)
`define EXT_FILT_NS 200
`define EXT_FILT_CYC ((`EXT_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// cause flag reset value
`define CAUSE_RESET 6'h00
`endif

/* rst_glitch_filter.v */
// glitch filter for the external reset input
// assumes the input is already synchronised to clk_sys
`timescale 1ns/1ps
module rst_glitch_filter #(
   parameter CYCLES = 20
) (
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // filtered signal
   input wire level_in,
   output reg level_out
);
   reg [15:0] cnt_q;

   // output follows input only after it held steady for CYCLES clocks
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         cnt_q <= 16'h0000;
         level_out <= 1'b1;
      end else if (level_in == level_out) begin
         cnt_q <= 16'h0000;
      end else if (cnt_q >= CYCLES[15:0] - 16'h0001) begin
         cnt_q <= 16'h0000;
         level_out <= level_in;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule

/* reset_source_and_config_decode.v */
// reset source combination and configuration word decode
// assumes clk_sys is free running; supply monitor levels and pin are asynchronous
`timescale 1ns/1ps
`include "rst_seq_consts.vh"

// Operation
// - brown-out mode field selects detection enable
// - data protect bit: 1 off, 0 on
// - pin is reset when enabled, else input
// - powerup delay bit active low
// - watchdog always on or soft enabled
// - three-bit field chooses clock source
// - six distinct reset causes are told apart
// - immune registers cleared only by power-on
// - ordinary reset skipped on watchdog wake-up
// - external reset input is glitch filtered
// - hold reset until supply is sufficient
// - hold reset until above brown-out threshold
// - power-on rearms after 100 us at ground
// - powerup timer adds 64 ms after power-on/brown-out
// - power-on flag cleared by power-on only
module reset_source_and_config_decode #(
   parameter DELAY_CYCLES = `PUP_DELAY_CYC,
   parameter REARM_CYCLES = `POR_REARM_CYC,
   parameter FILT_CYCLES = `EXT_FILT_CYC
) (
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // configuration word
   input wire [13:0] config_word,
   // software control bits
   input wire soft_brownout_enable,
   input wire soft_watchdog_enable,
   input wire power_flag_set,
   // supply monitors and pins, asynchronous
   input wire supply_ok,
   input wire supply_at_ground,
   input wire below_brownout_threshold,
   input wire external_reset_pin_n,
   // events from core logic
   input wire watchdog_timeout,
   input wire sleeping,
   // decoded configuration
   output reg brownout_enable,
   output reg data_protect_on,
   output reg code_protect_on,
   output reg ext_reset_pin_enable,
   output reg pin_digital_input,
   output reg powerup_delay_on,
   output reg watchdog_run,
   output reg [7:0] osc_mode,
   // reset outputs
   output wire sys_reset_n,
   output reg immune_reset_n,
   output reg ordinary_reset_n,
   output reg watchdog_wake,
   // cause flags
   output reg [5:0] reset_cause,
   output reg power_on_flag,
   output reg timeout_flag,
   output reg powerdown_flag
);
   localparam ST_RUN = 3'b001;
   localparam ST_HOLD = 3'b010;
   localparam ST_DELAY = 3'b100;

   // cause bit indices
   localparam C_POR = 0;
   localparam C_WDT_RUN = 1;
   localparam C_WDT_SLP = 2;
   localparam C_EXT_RUN = 3;
   localparam C_EXT_SLP = 4;
   localparam C_BOR = 5;

   reg [2:0] state_q;
   reg [3:0] meta_q;
   reg [3:0] sync_q;
   reg [31:0] delay_cnt_q;
   reg [31:0] gnd_cnt_q;
   reg por_armed_q;
   reg por_hold_q;
   reg rel_meta_q;
   reg rel_q;
   reg [5:0] cause_d;
   reg hold_req;
   wire pin_filt;
   wire ext_req;
   wire bor_req;
   wire src_active;
   wire [1:0] bor_mode;
   wire [2:0] osc_code;

   assign bor_mode = config_word[`CFG_BOR_MSB:`CFG_BOR_LSB];
   assign osc_code = config_word[`CFG_OSC_MSB:`CFG_OSC_LSB];

   // one-hot oscillator decode, used only by the osc_mode output
   function [7:0] osc_decode;
      input [2:0] code;
      begin
         osc_decode = 8'h01 << code;
      end
   endfunction

   // configuration decode, purely combinational from the word, sleeping and the software control bits
   always @* begin
      case (bor_mode)
         `BOR_MODE_ALWAYS: brownout_enable = 1'b1;
         `BOR_MODE_RUN: brownout_enable = !sleeping;
         `BOR_MODE_SOFT: brownout_enable = soft_brownout_enable;
         default: brownout_enable = 1'b0;
      endcase
      data_protect_on = !config_word[`CFG_DATAPROT_BIT];
      code_protect_on = !config_word[`CFG_CODEPROT_BIT];
      ext_reset_pin_enable = config_word[`CFG_EXTRST_BIT];
      pin_digital_input = !config_word[`CFG_EXTRST_BIT];
      powerup_delay_on = !config_word[`CFG_DELAY_DIS_BIT];
      watchdog_run = config_word[`CFG_WDT_BIT] | soft_watchdog_enable;
      osc_mode = osc_decode(osc_code);
   end

   // two-flop synchronisers: supply_ok, ground, brown-out, pin
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         meta_q <= 4'h0;
         sync_q <= 4'h0;
      end else begin
         meta_q <= {!external_reset_pin_n, below_brownout_threshold,
                    supply_at_ground, supply_ok};
         sync_q <= meta_q;
      end
   end

   // pin level is filtered so short pulses are ignored
   rst_glitch_filter #(
      .CYCLES(FILT_CYCLES)
   ) u_filt (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .level_in(!sync_q[3]),
      .level_out(pin_filt)
   );

   // internal reset line tied inactive when the pin is a digital input
   assign ext_req = ext_reset_pin_enable & !pin_filt;
   assign bor_req = brownout_enable & sync_q[2];

   // power-on detector: fires once, rearms only after long ground time
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         gnd_cnt_q <= 32'h0000_0000;
         por_armed_q <= 1'b1;
         por_hold_q <= 1'b1;
      end else begin
         if (sync_q[1]) begin
            if (gnd_cnt_q >= REARM_CYCLES - 1) begin
               por_armed_q <= 1'b1;
               por_hold_q <= 1'b1;
            end else begin
               gnd_cnt_q <= gnd_cnt_q + 32'h0000_0001;
            end
         end else begin
            gnd_cnt_q <= 32'h0000_0000;
         end
         // a falling supply re-asserts only through the ground-time rearm: hold only while armed
         if (por_armed_q && sync_q[0] && !sync_q[1]) begin
            por_hold_q <= 1'b0;
            por_armed_q <= 1'b0;
         end
      end
   end

   assign src_active = por_hold_q | bor_req | ext_req | watchdog_timeout;

   // cause classification of whatever source is active now
   always @* begin
      cause_d = `CAUSE_RESET;
      cause_d[C_POR] = por_hold_q;
      cause_d[C_BOR] = bor_req & !por_hold_q;
      cause_d[C_WDT_RUN] = watchdog_timeout & !sleeping;
      cause_d[C_WDT_SLP] = watchdog_timeout & sleeping;
      cause_d[C_EXT_RUN] = ext_req & !sleeping;
      cause_d[C_EXT_SLP] = ext_req & sleeping;
      hold_req = por_hold_q | bor_req | ext_req;
   end

   // sequencer: hold while power-on, brown-out or pin sources are active (not the watchdog), then optional powerup delay
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         state_q <= ST_HOLD;
         delay_cnt_q <= 32'h0000_0000;
      end else begin
         case (state_q)
            ST_RUN: begin
               if (hold_req) begin
                  state_q <= ST_HOLD;
               end
            end
            ST_HOLD: begin
               delay_cnt_q <= 32'h0000_0000;
               if (!hold_req) begin
                  state_q <= (powerup_delay_on && (reset_cause[C_POR] | reset_cause[C_BOR]))
                             ? ST_DELAY : ST_RUN;
               end
            end
            ST_DELAY: begin
               // a brown-out during the delay restarts it
               if (hold_req) begin
                  state_q <= ST_HOLD;
               end else if (delay_cnt_q >= DELAY_CYCLES - 1) begin
                  state_q <= ST_RUN;
               end else begin
                  delay_cnt_q <= delay_cnt_q + 32'h0000_0001;
               end
            end
            default: state_q <= ST_HOLD;
         endcase
      end
   end

   // release is synchronous through two flops; assert is immediate
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         rel_meta_q <= 1'b0;
         rel_q <= 1'b0;
      end else if (src_active || state_q != ST_RUN) begin
         rel_meta_q <= 1'b0;
         rel_q <= 1'b0;
      end else begin
         rel_meta_q <= 1'b1;
         rel_q <= rel_meta_q;
      end
   end
   // combinational assert path so any source drops reset at once
   assign sys_reset_n = rel_q & !src_active & reset_n;

   // register-init strobes: immune only on power-on, ordinary except wake
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         immune_reset_n <= 1'b0;
         ordinary_reset_n <= 1'b0;
         watchdog_wake <= 1'b0;
      end else begin
         immune_reset_n <= !por_hold_q;
         ordinary_reset_n <= !(hold_req | (watchdog_timeout & !sleeping)
                               | (state_q != ST_RUN));
         watchdog_wake <= watchdog_timeout & sleeping;
      end
   end

   // cause flags; software set of power-on flag loses to a new power-on
   always @(posedge clk_sys) begin
      if (!reset_n) begin
         reset_cause <= `CAUSE_RESET;
         power_on_flag <= 1'b0;
         timeout_flag <= 1'b1;
         powerdown_flag <= 1'b1;
      end else begin
         if (src_active) begin
            reset_cause <= cause_d;
         end
         if (por_hold_q) begin
            power_on_flag <= 1'b0;
            timeout_flag <= 1'b1;
            powerdown_flag <= 1'b1;
         end else begin
            if (power_flag_set) begin
               power_on_flag <= 1'b1;
            end
            if (watchdog_timeout) begin
               timeout_flag <= 1'b0;
               powerdown_flag <= !sleeping;
            end else if (ext_req && sleeping) begin
               timeout_flag <= 1'b1;
               powerdown_flag <= 1'b0;
            end else if (bor_req) begin
               timeout_flag <= 1'b1;
               powerdown_flag <= 1'b1;
            end
         end
      end
   end
endmodule

/* supply_pin_model.sv */
// supply monitors and external reset pin as the device sees them
// assumes the bench calls put; levels change only at falling edges
`timescale 1ns/1ps
module supply_pin_model (
   // clock
   input wire clk_sys,
   // monitor levels and pin
   output reg supply_ok,
   output reg supply_at_ground,
   output reg below_brownout_threshold,
   output reg external_reset_pin_n
);
   // dead supply at time zero; pin rests high on its pull-up
   initial begin
      supply_ok = 1'b0;
      supply_at_ground = 1'b1;
      below_brownout_threshold = 1'b1;
      external_reset_pin_n = 1'b1;
   end
   // ok, ground, below, pin; held for n cycles so slow answers are possible
   task put(input [3:0] v, input integer n);
      begin
         @(negedge clk_sys);
         {supply_ok, supply_at_ground, below_brownout_threshold, external_reset_pin_n} = v;
         repeat (n) @(negedge clk_sys);
      end
   endtask
endmodule

/* rst_seq_asserts.sv */
// assertions on the reset sequencer ports
// assumes it is bound into every reset_source_and_config_decode
`timescale 1ns/1ps
module rst_seq_asserts (
   // clock and reset
   input wire clk_sys,
   input wire reset_n,
   // inputs watched
   input wire [13:0] config_word,
   input wire soft_brownout_enable,
   input wire soft_watchdog_enable,
   input wire power_flag_set,
   input wire below_brownout_threshold,
   input wire sleeping,
   // outputs watched
   input wire brownout_enable,
   input wire data_protect_on,
   input wire ext_reset_pin_enable,
   input wire pin_digital_input,
   input wire powerup_delay_on,
   input wire watchdog_run,
   input wire [7:0] osc_mode,
   input wire sys_reset_n,
   input wire ordinary_reset_n,
   input wire watchdog_wake,
   input wire power_on_flag
);
   // one domain, so clock and disable are given once
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   property p_bor_mode;
      brownout_enable == (config_word[9:8] == 2'b11 || (config_word[9:8] == 2'b10 &&
         !sleeping) || (config_word[9:8] == 2'b01 && soft_brownout_enable));
   endproperty
   a_bor_mode: assert property (p_bor_mode) else $error("brown-out enable wrong");
   property p_data_prot;
      data_protect_on != config_word[7];
   endproperty
   a_data_prot: assert property (p_data_prot) else $error("data protect wrong");
   property p_pin_role;
      ext_reset_pin_enable == config_word[5] && pin_digital_input != config_word[5];
   endproperty
   a_pin_role: assert property (p_pin_role) else $error("pin role wrong");
   property p_delay_on;
      powerup_delay_on != config_word[4];
   endproperty
   a_delay_on: assert property (p_delay_on) else $error("delay enable wrong");
   property p_wdt_run;
      watchdog_run == (config_word[3] || soft_watchdog_enable);
   endproperty
   a_wdt_run: assert property (p_wdt_run) else $error("watchdog run wrong");
   property p_osc;
      osc_mode == (8'h01 << config_word[2:0]);
   endproperty
   a_osc: assert property (p_osc) else $error("osc mode wrong");
   // sync flops take two edges, so four samples leave margin
   property p_bor_hold;
      (brownout_enable && below_brownout_threshold) [*4] |-> !sys_reset_n;
   endproperty
   a_bor_hold: assert property (p_bor_hold) else $error("no brown-out hold");
   property p_wake;
      watchdog_wake |-> ordinary_reset_n;
   endproperty
   a_wake: assert property (p_wake) else $error("wake reset registers");
   property p_flag_set;
      $rose(power_on_flag) |-> $past(power_flag_set);
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag set uncaused");
endmodule

bind reset_source_and_config_decode rst_seq_asserts i_chk (.*);

/* tb_top.sv */
// self-checking bench for the reset sequencer and option decode
// assumes the supply model and bound checker compile first
`timescale 1ns/1ps
module tb_top;
   reg clk_sys, reset_n, soft_brownout_enable, soft_watchdog_enable, power_flag_set;
   reg watchdog_timeout, sleeping, s_low, s_ord, s_wake, s_imm;
   reg [13:0] config_word;
   reg [31:0] seed;
   wire supply_ok, supply_at_ground, below_brownout_threshold, external_reset_pin_n;
   wire brownout_enable, data_protect_on, code_protect_on, ext_reset_pin_enable;
   wire pin_digital_input, powerup_delay_on, watchdog_run, sys_reset_n, immune_reset_n;
   wire ordinary_reset_n, watchdog_wake, power_on_flag, timeout_flag, powerdown_flag;
   wire [7:0] osc_mode;
   wire [5:0] reset_cause;
   integer n_errors, checks_done, i, n;
   // short counts keep the run brief
   reset_source_and_config_decode #(.DELAY_CYCLES(50), .REARM_CYCLES(5), .FILT_CYCLES(3))
      i_dut (.*);
   supply_pin_model i_sup (.*);
   function [31:0] xs(input [31:0] s);
      reg [31:0] t;
      begin
         t = s ^ (s << 13);
         t = t ^ (t >> 17);
         xs = t ^ (t << 5);
      end
   endfunction
   function exp_bor(input [1:0] m, input sb, input sl);
      exp_bor = m == 2'b11 || (m == 2'b10 && !sl) || (m == 2'b01 && sb);
   endfunction
   task stop_test;
      begin
         $display("checks %0d errors %0d", checks_done, n_errors);
         if (n_errors == 0 && checks_done > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   task chk(input ok, input [127:0] msg);
      begin
         checks_done = checks_done + 1;
         if (ok !== 1'b1) begin
            n_errors = n_errors + 1;
            $display("wrong value at %0t: %0s", $time, msg);
         end
      end
   endtask
   // bounded wait for internal reset to reach level v
   task wait_rst(input v, input integer lim);
      begin
         n = 0;
         while (sys_reset_n !== v && n < lim) begin
            @(negedge clk_sys);
            n = n + 1;
         end
         if (n >= lim) begin
            chk(1'b0, "timeout");
            stop_test;
         end
      end
   endtask
   // sticky observers, cleared by the bench before the checks that read them
   always @(negedge clk_sys) begin
      if (sys_reset_n !== 1'b1) s_low = 1'b1;
      if (ordinary_reset_n !== 1'b1) s_ord = 1'b1;
      if (watchdog_wake === 1'b1) s_wake = 1'b1;
      if (immune_reset_n !== 1'b1) s_imm = 1'b1;
   end
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      {n_errors, checks_done, seed} = {32'd0, 32'd0, 32'h0000_157f};
      {reset_n, soft_brownout_enable, soft_watchdog_enable, power_flag_set} = 4'h0;
      {watchdog_timeout, sleeping, s_low, s_ord, s_wake, s_imm} = 6'h00;
      config_word = 14'h03f4;
      repeat (4) @(negedge clk_sys);
      reset_n = 1'b1;
      i_sup.put(4'b0001, 1);
      i_sup.put(4'b1001, 0);
      wait_rst(1'b1, 40);
      chk(reset_cause[0] === 1'b1 && power_on_flag === 1'b0, "por cause");
      chk(timeout_flag === 1'b1 && powerdown_flag === 1'b1, "por flags");
      power_flag_set = 1'b1;
      @(negedge clk_sys) power_flag_set = 1'b0;
      chk(power_on_flag === 1'b1, "flag set");
      $display("test power-on done");
      // every osc code, random rest; pin high, supply good
      for (i = 0; i < 40; i = i + 1) begin
         @(negedge clk_sys);
         seed = xs(seed);
         config_word = {seed[13:3], i[2:0]};
         {soft_brownout_enable, soft_watchdog_enable, sleeping} = seed[22:20];
         #1;
         chk(brownout_enable === exp_bor(seed[9:8], seed[22], seed[20]), "bor");
         chk(data_protect_on === ~config_word[7], "data prot");
         chk(code_protect_on === ~config_word[6], "code prot");
         chk(pin_digital_input === ~config_word[5], "pin role");
         chk(ext_reset_pin_enable === config_word[5], "pin enable");
         chk(powerup_delay_on === ~config_word[4], "delay");
         chk(watchdog_run === (config_word[3] | seed[21]), "wdt");
         chk(osc_mode === (8'h01 << i[2:0]), "osc");
      end
      $display("test decode done");
      {soft_brownout_enable, soft_watchdog_enable, sleeping} = 3'b000;
      config_word = 14'h03d4;
      s_low = 1'b0;
      i_sup.put(4'b1000, 8);
      i_sup.put(4'b1001, 8);
      chk(s_low === 1'b0, "pin off");
      config_word[5] = 1'b1;
      i_sup.put(4'b1000, 1);
      i_sup.put(4'b1001, 8);
      chk(s_low === 1'b0, "glitch");
      // supply sag without reaching ground must not re-trigger power-on
      i_sup.put(4'b0001, 3);
      i_sup.put(4'b1001, 8);
      chk(s_low === 1'b0, "sag");
      $display("test refusals done");
      s_imm = 1'b0;
      for (i = 0; i < 2; i = i + 1) begin
         sleeping = i[0];
         s_low = 1'b0;
         i_sup.put(4'b1000, 10);
         i_sup.put(4'b1001, 0);
         wait_rst(1'b1, 40);
         chk(s_low === 1'b1 && reset_cause[3 + i] === 1'b1, "pin cause");
         chk(timeout_flag === 1'b1 && powerdown_flag === ~i[0], "pin flags");
         chk(power_on_flag === 1'b1, "flag kept");
         @(negedge clk_sys);
         {s_ord, s_wake} = 2'b00;
         watchdog_timeout = 1'b1;
         repeat (2) @(negedge clk_sys);
         watchdog_timeout = 1'b0;
         repeat (6) @(negedge clk_sys);
         wait_rst(1'b1, 40);
         chk(s_ord === ~i[0] && s_wake === i[0], "wdt ord");
         chk(reset_cause[1 + i] === 1'b1, "wdt cause");
         chk(timeout_flag === 1'b0 && powerdown_flag === ~i[0], "wdt flags");
      end
      sleeping = 1'b0;
      $display("test pin and watchdog done");
      config_word[4] = 1'b0;
      i_sup.put(4'b1011, 6);
      i_sup.put(4'b1001, 0);
      wait_rst(1'b1, 200);
      chk(n >= 50 && n <= 60 && reset_cause[5] === 1'b1, "bor delay");
      chk(timeout_flag === 1'b1 && powerdown_flag === 1'b1, "bor flags");
      chk(power_on_flag === 1'b1, "flag kept");
      chk(s_imm === 1'b0, "immune kept");
      $display("test brown-out done");
      // long ground time rearms the power-on detector
      s_imm = 1'b0;
      i_sup.put(4'b0101, 10);
      i_sup.put(4'b1001, 0);
      wait_rst(1'b1, 200);
      chk(reset_cause[0] === 1'b1 && power_on_flag === 1'b0, "rearm");
      chk(s_imm === 1'b1, "immune init");
      $display("test rearm done");
      stop_test;
   end
endmodule
